/* sram_port_consts.svh */
/*
 * Constants for the synchronous dual-port RAM read port: widths, register
 * offsets, status field positions, reset values and deselect timing.
 * Assumes inclusion by bare name from every file that needs a figure.
 */
`ifndef SRAM_PORT_CONSTS_SVH
`define SRAM_PORT_CONSTS_SVH

// Array shape
`define ADDR_W 18
`define DATA_W 18
`define LANE_W 9
`define LANES 2
`define MEM_DEPTH 32'h0004_0000

// Register bus shape
`define AXI_ADDR_W 12
`define AXI_DATA_W 32

// Register byte offsets
`define REG_LOAD_ADDR 12'h000
`define REG_LOAD_DATA 12'h004
`define REG_STATUS 12'h008

// Status field positions
`define STAT_ADDR_LSB 0
`define STAT_DRIVE_BIT 20
`define STAT_PIPE_BIT 21
`define STAT_RUN_LSB 22

// Reset values
`define LOAD_ADDR_RESET 18'h00000
`define COUNTER_RESET 18'h00000

// Selected cycles needed before the outputs drive again
`define SEL_RUN_DRIVE 2'h2

// Bus responses
`define RESP_OKAY 2'h0
`define RESP_DECERR 2'h3

`endif

/* sram_port_pkg.sv */
/*
 * Types shared by the read port: output mode and register read channel state.
 * Assumes nothing of its surroundings; constants live in sram_port_consts.svh.
 */
`default_nettype none

package sram_port_pkg;

	// Output timing chosen by the strap
	typedef enum logic [1:0] {
		MODE_FLOW = 2'b01,
		MODE_PIPE = 2'b10
	} output_mode_type;

	// Register read channel
	typedef enum logic [1:0] {
		RD_IDLE = 2'b01,
		RD_ANSWER = 2'b10
	} read_state_type;

endpackage : sram_port_pkg

`default_nettype wire

/* port_sram_array.sv */
/*
 * Memory array of the port: one write port for software loading and one
 * read port whose data come out of a register one edge after the address.
 * Assumes a single clock; a read and write of one word in one cycle
 * returns the old word.
 */
`timescale 1ns/1ns
`default_nettype none
`include "sram_port_consts.svh"

module port_sram_array (
	// Clock
	input wire logic clk,
	// Read side
	input wire logic [`ADDR_W-1:0] read_address,
	output logic [`DATA_W-1:0] read_word,
	// Write side
	input wire logic write_enable,
	input wire logic [`ADDR_W-1:0] write_address,
	input wire logic [`DATA_W-1:0] write_word
);

	logic [`DATA_W-1:0] cells [0:`MEM_DEPTH-1];

	// Registered read; no reset so the array maps onto block memory
	always_ff @(posedge clk)
	begin
		read_word <= cells[read_address];
	end

	// Software load path
	always_ff @(posedge clk)
	begin
		if (write_enable)
		begin
			cells[write_address] <= write_word;
		end
	end

endmodule : port_sram_array

`default_nettype wire

/* burst_address_counter.sv */
/*
 * Internal address source of the port: loads the pin address on a strobe,
 * otherwise advances by one or holds. The access address is combinational
 * so that a flow-through read uses the address sampled on this very edge.
 * Assumes inputs synchronous to clk.
 */
`timescale 1ns/1ns
`default_nettype none
`include "sram_port_consts.svh"

module burst_address_counter (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Address controls from the pins
	input wire logic [`ADDR_W-1:0] external_address,
	input wire logic address_load_strobe_n,
	input wire logic counter_advance_enable_n,
	// Address for this edge and the held counter
	output logic [`ADDR_W-1:0] access_address,
	output logic [`ADDR_W-1:0] counter_value
);

	// Select the address for the access taken on this edge
	always_comb
	begin
		if (!address_load_strobe_n)
			access_address = external_address; // see R7, see R12
		else if (!counter_advance_enable_n)
			access_address = counter_value + `ADDR_W'(1); // see R13
		else
			access_address = counter_value; // see R12
	end

	// Counter remembers the last access; wraps at the top of the array
	always_ff @(posedge clk)
	begin
		if (!rst_n)
			counter_value <= `COUNTER_RESET;
		else
			counter_value <= access_address;
	end

endmodule : burst_address_counter

`default_nettype wire

/* sram_read_port.sv */
/*
 * One port of the synchronous dual-port RAM, read path: registered pin
 * sampling, burst address counter, flow-through or pipelined output,
 * chip-select deselect with two-cycle reactivation, byte lane disable and
 * an asynchronous output enable. Software loads the array and reads the
 * port state over an AXI4-Lite slave.
 * Assumes the bus master of the port drives its pins synchronously to clk,
 * and that the mode strap and output enable are the only asynchronous pins.
 */
`timescale 1ns/1ns
`default_nettype none
`include "sram_port_consts.svh"

// Behaviour
// R1: Strap high gives registered pipelined read data, independently per port.
// R2: Strap low gives flow-through read data, no extra cycle of latency.
// R3: All port inputs are sampled on the rising clock, except enable and strap.
// R4: The master keeps the strap steady while accesses are under way.
// R5: Output enable gates the data drivers combinationally, without a clock.
// R6: A sampled deselect floats the data outputs after that edge.
// R7: With the load strobe low, every edge captures the pin address.
// R8: A byte enable sampled high floats that lane when its data would show.
// R9: Banked devices share one address; chip enables pick the sole driver.
// R10: Pipelined data follow edge n+1; flow-through data follow edge n.
// R11: After a deselect, two selected cycles pass before outputs drive again.
// R12: Access address is the pin address when loading, else the counter.
// R13: Advance low with load high steps the access address by one.
module sram_read_port (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Port address and controls
	input wire logic [`ADDR_W-1:0] address_in,
	input wire logic chip_select_low_active,
	input wire logic chip_select_high_active,
	input wire logic upper_byte_lane_enable_n,
	input wire logic lower_byte_lane_enable_n,
	input wire logic address_load_strobe_n,
	input wire logic counter_advance_enable_n,
	// Asynchronous pins
	input wire logic output_enable_n,
	input wire logic output_mode_strap,
	// Read data pins, per-lane drive enable
	output logic [`DATA_W-1:0] read_data_out,
	output logic [`LANES-1:0] read_data_oe,
	// AXI4-Lite write channels
	input wire logic [`AXI_ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [`AXI_DATA_W-1:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// AXI4-Lite read channels
	input wire logic [`AXI_ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [`AXI_DATA_W-1:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);

	// Word offset of a byte address, shared by both decoders
	function automatic logic [`AXI_ADDR_W-1:0] word_offset(input logic [`AXI_ADDR_W-1:0] byte_addr);
		word_offset = {byte_addr[`AXI_ADDR_W-1:2], 2'h0};
	endfunction : word_offset

	// Merge a write under its byte strobes
	function automatic logic [`AXI_DATA_W-1:0] merge_strobes(input logic [`AXI_DATA_W-1:0] old_word,
		input logic [`AXI_DATA_W-1:0] new_word, input logic [3:0] strobes);
		merge_strobes = old_word;
		for (int i = 0; i < 4; i++)
		begin
			if (strobes[i])
				merge_strobes[i*8 +: 8] = new_word[i*8 +: 8];
		end
	endfunction : merge_strobes

	// Strap synchroniser and mode
	logic strap_meta;
	logic strap_sync;
	sram_port_pkg::output_mode_type mode;

	// Port pipeline state
	logic [1:0] select_run;
	logic [`LANES-1:0] lanes_flow;
	logic [`LANES-1:0] lanes_pipe;
	logic [`DATA_W-1:0] pipe_word;
	logic selected_now;
	logic drive;
	logic [`LANES-1:0] lanes_now;

	// Address and array wiring
	logic [`ADDR_W-1:0] access_address;
	logic [`ADDR_W-1:0] counter_value;
	logic [`DATA_W-1:0] array_word;

	// Register state
	logic [`ADDR_W-1:0] load_address;
	logic aw_held;
	logic w_held;
	logic [`AXI_ADDR_W-1:0] aw_addr;
	logic [`AXI_DATA_W-1:0] w_data;
	logic [3:0] w_strb;
	logic write_fire;
	logic load_write;
	sram_port_pkg::read_state_type read_state;
	logic [`AXI_DATA_W-1:0] status_word;

	// Strap is a DC level from a pin: two flops, second one read only
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			strap_meta <= 1'b0;
			strap_sync <= 1'b0;
		end
		else
		begin
			strap_meta <= output_mode_strap;
			strap_sync <= strap_meta;
		end
	end

	// Mode follows the strap; toggling it mid-burst garbles one word
	always_ff @(posedge clk)
	begin
		if (!rst_n)
			mode <= sram_port_pkg::MODE_FLOW;
		else if (strap_sync)
			mode <= sram_port_pkg::MODE_PIPE; // see R1, see R4
		else
			mode <= sram_port_pkg::MODE_FLOW; // see R2
	end

	// Both chip selects must agree for the port to be selected
	assign selected_now = !chip_select_low_active && chip_select_high_active;

	// Selected-cycle run; a deselect restarts it and floats on the same edge
	always_ff @(posedge clk)
	begin
		if (!rst_n)
			select_run <= 2'h0;
		else if (!selected_now)
			select_run <= 2'h0; // see R6, see R9
		else if (select_run != `SEL_RUN_DRIVE)
			select_run <= select_run + 2'h1; // see R11
	end

	assign drive = (select_run == `SEL_RUN_DRIVE); // see R11

	// Byte enables sampled with the access, delayed with pipelined data
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			lanes_flow <= '0;
			lanes_pipe <= '0;
		end
		else
		begin
			lanes_flow <= {!upper_byte_lane_enable_n, !lower_byte_lane_enable_n}; // see R3, see R8
			lanes_pipe <= lanes_flow; // see R8
		end
	end

	// Internal address: load, advance or hold
	burst_address_counter address_counter (
		.clk(clk),
		.rst_n(rst_n),
		.external_address(address_in),
		.address_load_strobe_n(address_load_strobe_n),
		.counter_advance_enable_n(counter_advance_enable_n),
		.access_address(access_address),
		.counter_value(counter_value)
	);

	// Array read lands one edge after the sampled address
	port_sram_array array (
		.clk(clk),
		.read_address(access_address), // see R3
		.read_word(array_word),
		.write_enable(load_write),
		.write_address(load_address),
		.write_word(w_data[`DATA_W-1:0])
	);

	// Output register of the pipelined mode
	always_ff @(posedge clk)
	begin
		if (!rst_n)
			pipe_word <= '0;
		else
			pipe_word <= array_word; // see R10
	end

	// Mode picks between two flops; the strap is static so no glitch path
	always_comb
	begin
		if (mode == sram_port_pkg::MODE_PIPE)
		begin
			read_data_out = pipe_word; // see R1, see R10
			lanes_now = lanes_pipe;
		end
		else
		begin
			read_data_out = array_word; // see R2, see R10
			lanes_now = lanes_flow;
		end
	end

	// Output enable acts without any clock edge
	assign read_data_oe = {`LANES{drive && !output_enable_n}} & lanes_now; // see R5, see R6, see R8

	// Write channels: take address and data in either order
	assign s_axi_awready = !aw_held && !s_axi_bvalid;
	assign s_axi_wready = !w_held && !s_axi_bvalid;
	assign write_fire = aw_held && w_held && !s_axi_bvalid;
	assign load_write = write_fire && (word_offset(aw_addr) == `REG_LOAD_DATA) && (w_strb != 4'h0);

	// Hold each write channel until both are in
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_addr <= '0;
			w_data <= '0;
			w_strb <= 4'h0;
		end
		else
		begin
			if (s_axi_awvalid && s_axi_awready)
			begin
				aw_held <= 1'b1;
				aw_addr <= s_axi_awaddr;
			end
			else if (write_fire)
				aw_held <= 1'b0;
			if (s_axi_wvalid && s_axi_wready)
			begin
				w_held <= 1'b1;
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
			end
			else if (write_fire)
				w_held <= 1'b0;
		end
	end

	// Write response, one cycle after both halves are held
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `RESP_OKAY;
		end
		else if (write_fire)
		begin
			s_axi_bvalid <= 1'b1;
			unique case (word_offset(aw_addr))
				`REG_LOAD_ADDR, `REG_LOAD_DATA, `REG_STATUS: s_axi_bresp <= `RESP_OKAY;
				default: s_axi_bresp <= `RESP_DECERR;
			endcase
		end
		else if (s_axi_bready)
			s_axi_bvalid <= 1'b0;
	end

	// Load pointer: written directly, stepped after each data word
	always_ff @(posedge clk)
	begin
		if (!rst_n)
			load_address <= `LOAD_ADDR_RESET;
		else if (write_fire && word_offset(aw_addr) == `REG_LOAD_ADDR)
			load_address <= `ADDR_W'(merge_strobes({14'h0000, load_address}, w_data, w_strb));
		else if (load_write)
			load_address <= load_address + `ADDR_W'(1);
	end

	// Port state for software
	always_comb
	begin
		status_word = '0;
		status_word[`STAT_ADDR_LSB +: `ADDR_W] = counter_value;
		status_word[`STAT_DRIVE_BIT] = drive;
		status_word[`STAT_PIPE_BIT] = (mode == sram_port_pkg::MODE_PIPE);
		status_word[`STAT_RUN_LSB +: 2] = select_run;
	end

	assign s_axi_arready = (read_state == sram_port_pkg::RD_IDLE);

	// Read channel: answer one cycle after the address is taken
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			read_state <= sram_port_pkg::RD_IDLE;
			s_axi_rdata <= '0;
			s_axi_rresp <= `RESP_OKAY;
		end
		else
		begin
			unique case (read_state)
				sram_port_pkg::RD_IDLE:
				begin
					if (s_axi_arvalid)
					begin
						read_state <= sram_port_pkg::RD_ANSWER;
						s_axi_rresp <= `RESP_OKAY;
						unique case (word_offset(s_axi_araddr))
							`REG_LOAD_ADDR: s_axi_rdata <= {14'h0000, load_address};
							`REG_LOAD_DATA: s_axi_rdata <= '0;
							`REG_STATUS: s_axi_rdata <= status_word;
							default:
							begin
								s_axi_rdata <= '0;
								s_axi_rresp <= `RESP_DECERR;
							end
						endcase
					end
				end
				sram_port_pkg::RD_ANSWER:
				begin
					if (s_axi_rready)
						read_state <= sram_port_pkg::RD_IDLE;
				end
			endcase
		end
	end

	assign s_axi_rvalid = (read_state == sram_port_pkg::RD_ANSWER);

endmodule : sram_read_port

`default_nettype wire

/* sram_port_props.sv */
/* Checker of the read port pins and register bus handshakes.
 * Assumes the bind at the foot onto every sram_read_port. */
`timescale 1ns/1ns
`default_nettype none
`include "sram_port_consts.svh"

module sram_port_props (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Port pins
	input wire logic chip_select_low_active,
	input wire logic chip_select_high_active,
	input wire logic upper_byte_lane_enable_n,
	input wire logic lower_byte_lane_enable_n,
	input wire logic address_load_strobe_n,
	input wire logic counter_advance_enable_n,
	input wire logic output_enable_n,
	input wire logic [`DATA_W-1:0] read_data_out,
	input wire logic [`LANES-1:0] read_data_oe,
	// Bus handshakes
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	// Either chip select off counts as a deselect
	wire logic desel = chip_select_low_active || !chip_select_high_active;
	wire logic lanes_on = !upper_byte_lane_enable_n && !lower_byte_lane_enable_n;
	wire logic hold = address_load_strobe_n && counter_advance_enable_n && !desel;

	// One edge of grace after reset, so no attempt straddles its release
	logic armed;
	always_ff @(posedge clk)
	begin
		armed <= rst_n;
	end

	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n || !armed);

	// Output drive and data timing
	a_oe_gate: assert property (output_enable_n |-> read_data_oe == 2'h0)
		else $error("drivers on while output enable is off");
	a_desel_float: assert property (desel |=> read_data_oe == 2'h0)
		else $error("drivers on after a deselect");
	a_reselect_wait: assert property (desel ##1 !desel |=> read_data_oe == 2'h0)
		else $error("drivers on after one selected cycle");
	a_drive_resume: assert property ((!desel && lanes_on)[*2] ##1 !output_enable_n |-> read_data_oe == 2'h3)
		else $error("drivers off after two selected cycles");
	a_lane_float: assert property (upper_byte_lane_enable_n[*2] |=> !read_data_oe[1])
		else $error("upper lane driven while disabled");
	a_hold_stable: assert property (hold[*3] |=> $stable(read_data_out))
		else $error("data moved while the address held");
	// Bus answers
	a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
		|=> !s_axi_bvalid ##1 s_axi_bvalid)
		else $error("write response not two edges after handshake");
	a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read data not one edge after address");
	a_read_done: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
		else $error("read data stayed after acceptance");

	// Main scenarios reached
	c_reselect: cover property (desel ##1 !desel ##1 !desel);
	c_lane_off: cover property (upper_byte_lane_enable_n[*2]);
	c_hold_run: cover property (hold[*3]);
endmodule : sram_port_props

bind sram_read_port sram_port_props chk (.*);

`default_nettype wire

/* port_master_model.sv */
/* Model of the master that drives the port pins.
 * Assumes one sram_read_port on the far side, sharing clk. */
`timescale 1ns/1ns
`default_nettype none
`include "sram_port_consts.svh"

module port_master_model (
	// Clock
	input wire logic clk,
	// Port pins
	output logic [`ADDR_W-1:0] address_in,
	output logic chip_select_low_active,
	output logic chip_select_high_active,
	output logic upper_byte_lane_enable_n,
	output logic lower_byte_lane_enable_n,
	output logic address_load_strobe_n,
	output logic counter_advance_enable_n,
	output logic output_enable_n,
	output logic output_mode_strap
);
	// Idle: selected, loading address zero, flow-through
	initial
	begin
		{chip_select_low_active, chip_select_high_active} = 2'b01;
		{address_load_strobe_n, counter_advance_enable_n} = 2'b01;
		{upper_byte_lane_enable_n, lower_byte_lane_enable_n} = 2'b00;
		{output_enable_n, output_mode_strap} = 2'b00;
		address_in = 18'h00000;
	end

	// One access, launched after an edge and sampled at the next
	task automatic drive(input logic [5:0] ctl, input logic [`ADDR_W-1:0] addr);
		@(posedge clk);
		{chip_select_low_active, chip_select_high_active} <= ctl[5:4];
		{address_load_strobe_n, counter_advance_enable_n} <= ctl[3:2];
		{upper_byte_lane_enable_n, lower_byte_lane_enable_n} <= ctl[1:0];
		// Lines wander when no load is asked, so stale values never help
		address_in <= ctl[3] ? ~address_in : addr;
	endtask : drive

	// Strap moves only between bursts, static otherwise
	task automatic set_mode(input logic v);
		@(posedge clk);
		output_mode_strap <= v;
	endtask : set_mode

	// Output enable, needs no access
	task automatic set_oe(input logic v);
		@(posedge clk);
		output_enable_n <= v;
	endtask : set_oe
endmodule : port_master_model

`default_nettype wire

/* tb_sync_dual_port_sram_port_read.sv */
/* Self-checking bench of one read port: loads the array over the register
 * bus, then reads through the pins in both output modes.
 * Assumes the master model and the bound checker. */
`timescale 1ns/1ns
`default_nettype none
`include "sram_port_consts.svh"

module tb_sync_dual_port_sram_port_read;
	logic clk;
	logic rst_n;
	logic [`ADDR_W-1:0] address_in;
	logic chip_select_low_active, chip_select_high_active, output_enable_n, output_mode_strap;
	logic upper_byte_lane_enable_n, lower_byte_lane_enable_n, address_load_strobe_n, counter_advance_enable_n;
	logic [`DATA_W-1:0] read_data_out;
	logic [1:0] read_data_oe, s_axi_bresp, s_axi_rresp;
	logic [11:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0] s_axi_wstrb;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	int n_fail = 0;
	int tests_run = 0;
	int cycles = 0;
	// Pin controls {cs_n, cs, load_n, advance_n, upper_n, lower_n}
	localparam logic [5:0] load_op = 6'b010100;
	localparam logic [5:0] adv_op = 6'b011000;
	localparam logic [5:0] hold_op = 6'b011100;
	localparam logic [5:0] hold_ub_op = 6'b011110;
	localparam logic [5:0] desel_n_op = 6'b111100;
	localparam logic [5:0] desel_op = 6'b001100;
	localparam logic [17:0] base = 18'h3FFFE;
	logic [17:0] words [4] = '{18'h2A5A5, 18'h15A5A, 18'h3FF00, 18'h000FF};

	sram_read_port uut (.*);
	port_master_model pm (.*);

	// Clock
	initial
	begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	// Verdict and end of run
	task automatic report_and_stop();
		if (n_fail == 0 && tests_run > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : report_and_stop

	// Cycle ceiling against a hung handshake
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 1000)
		begin
			n_fail++;
			report_and_stop();
		end
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] want);
		tests_run++;
		if (seen !== want)
		begin
			n_fail++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, want);
		end
	endtask : check

	// Address and data offered together, each dropped once taken
	task automatic axi_wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
		@(posedge clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
		do
		begin
			@(posedge clk);
			if (s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wready)
				s_axi_wvalid <= 1'b0;
		end
		while (!s_axi_bvalid);
		r = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask : axi_wr

	task automatic axi_rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge clk);
		s_axi_araddr <= a;
		{s_axi_arvalid, s_axi_rready} <= 2'h3;
		do
		begin
			@(posedge clk);
			if (s_axi_arready)
				s_axi_arvalid <= 1'b0;
		end
		while (!s_axi_rvalid);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask : axi_rd

	// Reset value, unmapped place, array filled across the top address
	task automatic regs_and_load();
		logic [31:0] d;
		logic [1:0] r;
		axi_rd(`REG_LOAD_ADDR, d, r);
		check(d, 32'h00000000);
		axi_rd(12'h00C, d, r);
		check(r, `RESP_DECERR);
		axi_wr(12'h00C, 32'h00000001, r);
		check(r, `RESP_DECERR);
		axi_wr(`REG_LOAD_ADDR, {14'h0000, base}, r);
		for (int k = 0; k < 4; k++)
		begin
			axi_wr(`REG_LOAD_DATA, {14'h0000, words[k]}, r);
			check(r, `RESP_OKAY);
		end
		axi_wr(`REG_STATUS, 32'hFFFFFFFF, r);
		check(r, `RESP_OKAY);
		axi_rd(`REG_LOAD_DATA, d, r);
		check(d, 32'h00000000);
		axi_rd(`REG_LOAD_ADDR, d, r);
		check(d, 32'h00000002);
	endtask : regs_and_load

	// Flow-through: load, advance through the wrap, hold with a lane off
	task automatic flow_reads();
		pm.drive(load_op, base);
		pm.drive(adv_op, 18'h00000);
		#1;
		check(read_data_out, words[0]);
		check(read_data_oe, 2'h3);
		pm.drive(adv_op, 18'h00000);
		#1;
		check(read_data_out, words[1]);
		pm.drive(hold_ub_op, 18'h00000);
		#1;
		check(read_data_out, words[2]);
		pm.drive(hold_ub_op, 18'h00000);
		#1;
		check(read_data_oe, 2'h1);
		pm.drive(load_op, 18'h00001);
		#1;
		check(read_data_out, words[2]);
		pm.drive(load_op, 18'h00001);
		#1;
		check(read_data_out, words[3]);
	endtask : flow_reads

	// Pipelined: back-to-back loads show one edge late
	task automatic pipe_reads();
		logic [31:0] d;
		logic [1:0] r;
		pm.set_mode(1'b1);
		repeat (4) pm.drive(load_op, 18'h00001);
		pm.drive(load_op, base);
		pm.drive(load_op, 18'h00000);
		#1;
		check(read_data_out, words[3]);
		pm.drive(load_op, 18'h00001);
		#1;
		check(read_data_out, words[0]);
		pm.drive(load_op, 18'h00001);
		#1;
		check(read_data_out, words[2]);
		pm.drive(hold_ub_op, 18'h00000);
		pm.drive(hold_ub_op, 18'h00000);
		#1;
		check(read_data_oe, 2'h3);
		pm.drive(load_op, 18'h00001);
		#1;
		check(read_data_oe, 2'h1);
		axi_rd(`REG_STATUS, d, r);
		check(d[`STAT_PIPE_BIT], 1'b1);
		pm.set_mode(1'b0);
		repeat (4) pm.drive(load_op, 18'h00001);
	endtask : pipe_reads

	// Deselect by either select, two-cycle reactivation, output enable
	task automatic deselect_reads();
		pm.drive(desel_n_op, 18'h00000);
		pm.drive(hold_op, 18'h00000);
		#1;
		check(read_data_oe, 2'h0);
		pm.drive(hold_op, 18'h00000);
		#1;
		check(read_data_oe, 2'h0);
		pm.drive(hold_op, 18'h00000);
		#1;
		check(read_data_oe, 2'h3);
		check(read_data_out, words[3]);
		pm.set_oe(1'b1);
		#1;
		check(read_data_oe, 2'h0);
		pm.set_oe(1'b0);
		#1;
		check(read_data_oe, 2'h3);
		pm.drive(desel_op, 18'h00000);
		pm.drive(hold_op, 18'h00000);
		#1;
		check(read_data_oe, 2'h0);
	endtask : deselect_reads

	// Reset in mid-run clears the pointer, the counter and the drive
	task automatic reset_midrun();
		logic [31:0] d;
		logic [1:0] r;
		@(posedge clk);
		rst_n <= 1'b0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		#1;
		check(read_data_oe, 2'h0);
		axi_rd(`REG_LOAD_ADDR, d, r);
		check(d, `LOAD_ADDR_RESET);
		#1;
		check(read_data_oe, 2'h3);
		check(read_data_out, words[2]);
	endtask : reset_midrun

	// Main sequence
	initial
	begin
		rst_n = 1'b0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 56'h0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
		s_axi_wstrb = 4'hF;
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		regs_and_load();
		flow_reads();
		pipe_reads();
		deselect_reads();
		reset_midrun();
		report_and_stop();
	end
endmodule : tb_sync_dual_port_sram_port_read

`default_nettype wire
